// *** bench/acct_asserts.sv ***
// Purpose: Port checks for acct_top
// Assumes: One clock domain, short calibration lengths
// Notes: Busy length counted in helper flops
`timescale 1ns/1ps
`default_nettype none
module acct_asserts
    import acct_pkg::*;
#(parameter int CAL_FULL_LEN = 40, parameter int CAL_DAC_FS_LEN = 30,
    parameter int CAL_OFFSET_LEN = 20) (
    // Watched ports
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic conversion_start_n,
    input wire logic cal_request,
    input wire logic [1:0] cal_kind,
    input wire logic busy,
    input wire logic rx_valid,
    input wire logic [2:0] interface_mode,
    input wire logic shift_clk_oe,
    input wire logic frame_select_n,
    input wire logic data_out_oe,
    input wire logic data_in_oe
);
    logic armed;
    logic [1:0] kind;
    int cnt;
    int len;
    wire logic int_m = interface_mode inside {MODE_INT_LO, MODE_INT_HI};
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) armed <= 1'b0;
        else if ($rose(cal_request)) armed <= 1'b1;
        else if (busy) armed <= 1'b0;
    end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) kind <= 2'h0;
        else if ($rose(cal_request)) kind <= cal_kind;
    end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) cnt <= 0;
        else cnt <= busy ? cnt + 1 : 0;
    end
    // Length fixed when busy starts, armed still visible then
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) len <= CONV_CYCLES;
        else if (busy && cnt == 0) len <= !armed ? CONV_CYCLES : kind == CAL_DAC_FS ?
            CAL_DAC_FS_LEN : kind == CAL_OFFSET ? CAL_OFFSET_LEN : CAL_FULL_LEN;
    end
    sequence s_start; $fell(conversion_start_n) && !busy; endsequence
    sequence s_up; ##[1:4] busy; endsequence
    property p_busy_rise; s_start |-> s_up; endproperty
    a_busy_rise: assert property (p_busy_rise) else $error("busy late");
    property p_cal_rise; s_start ##0 armed |-> ##[1:2] busy; endproperty
    a_cal_rise: assert property (p_cal_rise) else $error("cal busy late");
    property p_busy_len; $fell(busy) |-> cnt == len; endproperty
    a_busy_len: assert property (p_busy_len) else $error("busy length");
    property p_busy_hold; cnt != 0 && cnt < len |-> busy; endproperty
    a_busy_hold: assert property (p_busy_hold) else $error("busy dropped");
    property p_clk_oe; int_m[*3] |-> shift_clk_oe; endproperty
    a_clk_oe: assert property (p_clk_oe) else $error("clock not driven");
    property p_clk_off; (!int_m)[*3] |-> !shift_clk_oe; endproperty
    a_clk_off: assert property (p_clk_off) else $error("clock driven");
    property p_dout_on; (!frame_select_n)[*5] |-> data_out_oe; endproperty
    a_dout_on: assert property (p_dout_on) else $error("dout off");
    property p_dout_off; frame_select_n[*5] |-> !data_out_oe; endproperty
    a_dout_off: assert property (p_dout_off) else $error("dout on");
    property p_din_off; frame_select_n[*5] |-> !data_in_oe; endproperty
    a_din_off: assert property (p_din_off) else $error("din driven");
    property p_rx_pulse; rx_valid |-> !frame_select_n ##1 !rx_valid; endproperty
    a_rx_pulse: assert property (p_rx_pulse) else $error("rx pulse");
endmodule : acct_asserts
`default_nettype wire

// *** bench/acct_host.sv ***
// Purpose: Host serial port model
// Assumes: Modes 1-3, host makes the shift clock
// Notes: Clock idles between frames; released data line toggles
`timescale 1ns/1ps
`default_nettype none
module acct_host
    import acct_pkg::*;
(
    // Link pins
    input wire logic link_clk,
    input wire logic edge_select,
    input wire logic data_out,
    output logic shift_clk_in,
    output logic frame_select_n,
    output logic data_in,
    // Bench side
    input wire logic go,
    input wire logic [acct_pkg::WORD_W-1:0] tx_word,
    output logic [acct_pkg::WORD_W-1:0] rx_word,
    output logic done
);
    initial begin
        shift_clk_in = 1'b1;
        frame_select_n = 1'b1;
        data_in = 1'b0;
        done = 1'b0;
    end
    // 108 ns period, edges by edge_select
    always begin
        @(posedge link_clk);
        done <= 1'b0;
        if (!go) begin
            shift_clk_in <= edge_select;
            data_in <= ~data_in;
        end else begin
            frame_select_n <= 1'b0;
            for (int i = WORD_W - 1; i >= 0; i--) begin
                repeat (9) @(posedge link_clk);
                shift_clk_in <= ~edge_select;
                data_in <= tx_word[i];
                repeat (9) @(posedge link_clk);
                shift_clk_in <= edge_select;
                rx_word[i] <= data_out;
            end
            repeat (9) @(posedge link_clk);
            frame_select_n <= 1'b1;
            done <= 1'b1;
            wait (!go);
        end
    end
endmodule : acct_host
`default_nettype wire

// *** bench/tb_acct_top.sv ***
// Purpose: Self-checking bench for acct_top
// Assumes: Short calibration lengths
// Notes: Drivers queue expectations, monitors compare
`timescale 1ns/1ps
`default_nettype none
module tb_acct_top;
    import acct_pkg::*;
    logic sys_clk, link_clk, rst_n, conversion_start_n, cal_request, busy, go, done, taken;
    logic result_valid, result_ready, rx_valid, edge_select, shift_clk_in, shift_clk_out;
    logic shift_clk_oe, frame_select_n, data_out, data_out_oe, data_in, data_in_out, data_in_oe;
    logic [1:0] cal_kind;
    logic [2:0] interface_mode;
    logic [WORD_W-1:0] result_data, rx_data, tx_word, rx_word;
    logic [WORD_W-1:0] exp_rx[$], exp_tx[$];
    int exp_busy[$];
    int seed = 32'h68d85e67;
    int checked, bad_count, cycles, bcnt, feed_left;
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    initial begin
        link_clk = 1'b0;
        #1.3;
        forever #3 link_clk = ~link_clk;
    end
    acct_top #(.CAL_FULL_LEN(40), .CAL_DAC_FS_LEN(30), .CAL_OFFSET_LEN(20)) acct_top_i (
        .sys_clk(sys_clk), .rst_n(rst_n), .conversion_start_n(conversion_start_n),
        .cal_request(cal_request), .cal_kind(cal_kind), .busy(busy), .result_valid(result_valid),
        .result_ready(result_ready), .result_data(result_data), .rx_valid(rx_valid),
        .rx_data(rx_data), .interface_mode(interface_mode), .edge_select(edge_select),
        .shift_clk_in(shift_clk_in), .shift_clk_out(shift_clk_out), .shift_clk_oe(shift_clk_oe),
        .frame_select_n(frame_select_n), .data_out(data_out), .data_out_oe(data_out_oe),
        .data_in(data_in), .data_in_out(data_in_out), .data_in_oe(data_in_oe));
    acct_host acct_host_i (.link_clk(link_clk), .edge_select(edge_select), .data_out(data_out),
        .shift_clk_in(shift_clk_in), .frame_select_n(frame_select_n), .data_in(data_in),
        .go(go), .tx_word(tx_word), .rx_word(rx_word), .done(done));
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task complete_run;
        $display("checked %0d bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : complete_run
    task pulse_start;
        conversion_start_n = 1'b0;
        repeat (3) @(negedge sys_clk);
        conversion_start_n = 1'b1;
    endtask : pulse_start
    // Second start lands mid-busy and must be ignored
    task automatic run_busy(input int len, input logic cal, input logic [1:0] kind);
        cal_kind = kind;
        cal_request = cal;
        repeat (3) @(negedge sys_clk);
        cal_request = 1'b0;
        exp_busy.push_back(len);
        pulse_start();
        repeat (8) @(negedge sys_clk);
        pulse_start();
        repeat (len + 12) @(negedge sys_clk);
    endtask : run_busy
    task automatic frame(input logic [WORD_W-1:0] w);
        wait (!done);
        exp_rx.push_back(w);
        tx_word = w;
        go = 1'b1;
        wait (done);
        @(negedge sys_clk);
        go = 1'b0;
    endtask : frame
    always @(negedge sys_clk) begin
        if (rx_valid === 1'b1) chk("rx_data", exp_rx.pop_front(), rx_data);
        if (busy === 1'b1) bcnt++;
        else if (bcnt != 0) begin
            chk("busy_len", exp_busy.pop_front(), bcnt);
            bcnt = 0;
        end
    end
    always @(posedge done) chk("host_word", exp_tx.pop_front(), rx_word);
    // Request held until ready seen before the edge
    always @(negedge sys_clk) begin
        if (taken) begin
            result_data = WORD_W'($random(seed));
            result_valid = feed_left != 0;
        end
        taken = result_valid && result_ready === 1'b1;
        if (taken) begin
            exp_tx.push_back(result_data);
            feed_left--;
        end
    end
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            complete_run();
        end
    end
    initial begin
        {rst_n, cal_request, cal_kind, result_valid, result_data, go, tx_word, taken} = '0;
        conversion_start_n = 1'b1;
        interface_mode = 3'h1;
        edge_select = 1'b1;
        repeat (20) @(negedge sys_clk);
        rst_n = 1'b1;
        repeat (2) @(negedge sys_clk);
        run_busy(CONV_CYCLES, 1'b0, 2'h0);
        for (int k = 0; k < 4; k++)
            run_busy(k == 1 ? 30 : k == 2 ? 20 : 40, 1'b1, 2'(k));
        result_data = WORD_W'($random(seed));
        @(negedge sys_clk);
        feed_left = 4;
        result_valid = 1'b1;
        repeat (10) @(negedge sys_clk);
        chk("ready_full", 0, result_ready);
        for (int k = 0; k < 4; k++) begin
            interface_mode = 3'(1 + k % 3);
            edge_select = k[0];
            repeat (20) @(negedge sys_clk);
            frame(WORD_W'($random(seed)));
        end
        for (int m = 4; m < 6; m++) begin
            interface_mode = 3'(m);
            repeat (6) @(negedge sys_clk);
            chk("clk_oe", 1, shift_clk_oe);
            chk("clk_idle", edge_select, shift_clk_out);
            chk("din_oe", 0, data_in_oe);
        end
        chk("pending", 0, exp_rx.size() + exp_tx.size() + exp_busy.size());
        complete_run();
    end
endmodule : tb_acct_top
bind acct_top acct_asserts #(.CAL_FULL_LEN(CAL_FULL_LEN), .CAL_DAC_FS_LEN(CAL_DAC_FS_LEN),
    .CAL_OFFSET_LEN(CAL_OFFSET_LEN)) acct_asserts_i (.sys_clk(sys_clk), .rst_n(rst_n),
    .conversion_start_n(conversion_start_n), .cal_request(cal_request), .cal_kind(cal_kind),
    .busy(busy), .rx_valid(rx_valid), .interface_mode(interface_mode),
    .shift_clk_oe(shift_clk_oe), .frame_select_n(frame_select_n),
    .data_out_oe(data_out_oe), .data_in_oe(data_in_oe));
`default_nettype wire

// *** logic/acct_buf2.sv ***
// Purpose: Two-entry valid/ready buffer
// Assumes: Single clock
// Notes: Never drops a word while the reader stalls
`timescale 1ns/1ps
`default_nettype none
module acct_buf2 #(
    parameter int WIDTH = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    logic [WIDTH-1:0] mem [2];
    logic wr_ptr;
    logic rd_ptr;
    logic [1:0] count;
    logic push;
    logic pop;

    assign in_ready = (count != 2'h2);
    assign out_valid = (count != 2'h0);
    assign out_data = mem[rd_ptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count <= 2'h0;
        end else begin
            if (push) wr_ptr <= ~wr_ptr;
            if (pop) rd_ptr <= ~rd_ptr;
            count <= count + {1'b0, push} - {1'b0, pop};
        end
    end

    // Storage has no reset; valid gates it
    always_ff @(posedge clk) begin
        if (push) mem[wr_ptr] <= in_data;
    end
endmodule : acct_buf2
`default_nettype wire

// *** logic/acct_pkg.sv ***
// Purpose: Shared constants for the converter sequencing and serial port block
// Assumes: Master clock is sys_clk; shift clock in modes 1-3 is a separate domain
// Notes: Calibration counts are in master clock periods
package acct_pkg;
    localparam int CONV_CYCLES = 20;
    localparam int CAL_FULL_CYCLES = 250026;
    localparam int CAL_DAC_FS_CYCLES = 222228;
    localparam int CAL_OFFSET_CYCLES = 27798;
    localparam int BUSY_RISE_CYCLES = 2;
    localparam int CNT_W = 18;
    localparam int WORD_W = 16;
    localparam int BIT_W = 5;
    localparam logic [2:0] MODE_EXT_LO = 3'h1;
    localparam logic [2:0] MODE_EXT_HI = 3'h3;
    localparam logic [2:0] MODE_INT_LO = 3'h4;
    localparam logic [2:0] MODE_INT_HI = 3'h5;
    localparam logic [1:0] CAL_FULL = 2'h0;
    localparam logic [1:0] CAL_DAC_FS = 2'h1;
    localparam logic [1:0] CAL_OFFSET = 2'h2;
    typedef enum logic [1:0] {
        ACCT_IDLE,
        ACCT_CONV,
        ACCT_CAL
    } acct_seq_type;
endpackage : acct_pkg

// *** logic/acct_top.sv ***
// Purpose: Conversion and calibration sequencing with serial data port
// Assumes: Host drives frame select, data in and, in modes 1-3, the shift clock
// Notes: Port logic runs on sys_clk in all modes; the shift clock in modes 1-3 is sampled
//
// Contract
// (RULE_01) Busy rises after start falls; conversion lasts 20 master clock periods.
// (RULE_02) Busy rises on a falling edge of the start input.
// (RULE_03) Full self-calibration lasts 250026 master clock periods.
// (RULE_04) DAC plus system full-scale calibration lasts 222228 periods.
// (RULE_05) System offset calibration lasts 27798 periods.
// (RULE_06) In calibration, busy rises within 2.5 periods of start falling.
// (RULE_07) Host supplies shift clock in modes 1-3, at most 10 MHz.
// (RULE_08) In modes 4 and 5 device outputs shift clock at master rate. Code toggles it each master clock while frame select is low: half that rate.
// (RULE_09) Data out driven after frame select falls, released after it rises.
// (RULE_10) Bidirectional data pin leaves high impedance after frame select falls.
// (RULE_11) Data pin turns to output on rising edge, back to input later.
// (RULE_12) Launch on falling shift edge, capture on following rising edge.
// (RULE_13) Edge select low inverts every shift clock edge.
// (RULE_14) Busy holds through calibration until its full count elapses.
`timescale 1ns/1ps
`default_nettype none
module acct_top
    import acct_pkg::*;
#(
    parameter int CAL_FULL_LEN = acct_pkg::CAL_FULL_CYCLES,
    parameter int CAL_DAC_FS_LEN = acct_pkg::CAL_DAC_FS_CYCLES,
    parameter int CAL_OFFSET_LEN = acct_pkg::CAL_OFFSET_CYCLES,
    parameter int TX_BITS = acct_pkg::WORD_W
) (
    // Master clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Conversion control pins
    input wire logic conversion_start_n,
    input wire logic cal_request,
    input wire logic [1:0] cal_kind,
    output logic busy,
    // Result word from the converter core
    input wire logic result_valid,
    output logic result_ready,
    input wire logic [acct_pkg::WORD_W-1:0] result_data,
    // Received word toward the core
    output logic rx_valid,
    output logic [acct_pkg::WORD_W-1:0] rx_data,
    // Serial port configuration
    input wire logic [2:0] interface_mode,
    input wire logic edge_select,
    // Serial port pins
    input wire logic shift_clk_in,
    output logic shift_clk_out,
    output logic shift_clk_oe,
    input wire logic frame_select_n,
    output logic data_out,
    output logic data_out_oe,
    input wire logic data_in,
    output logic data_in_out,
    output logic data_in_oe
);
    import acct_pkg::*;

    function automatic logic mode_internal(input logic [2:0] m);
        mode_internal = (m >= MODE_INT_LO) && (m <= MODE_INT_HI);
    endfunction : mode_internal

    // Pin synchronisers on sys_clk
    logic [1:0] start_sync;
    logic [1:0] cal_sync;
    logic [1:0] frame_sync;
    logic [1:0] din_sync;
    logic [1:0] sck_sync;
    logic start_prev;
    logic cal_prev;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            start_sync <= 2'h3;
            cal_sync <= 2'h0;
            frame_sync <= 2'h3;
            din_sync <= 2'h0;
            sck_sync <= 2'h0;
            start_prev <= 1'b1;
            cal_prev <= 1'b0;
        end else begin
            start_sync <= {start_sync[0], conversion_start_n};
            cal_sync <= {cal_sync[0], cal_request};
            frame_sync <= {frame_sync[0], frame_select_n};
            din_sync <= {din_sync[0], data_in};
            sck_sync <= {sck_sync[0], shift_clk_in};
            start_prev <= start_sync[1];
            cal_prev <= cal_sync[1];
        end
    end

    logic start_fall;
    logic cal_rise;
    assign start_fall = start_prev && !start_sync[1];
    assign cal_rise = !cal_prev && cal_sync[1];

    // Sequencer
    acct_seq_type state;
    logic [CNT_W-1:0] count;
    logic cal_armed;
    logic [1:0] cal_sel;

    function automatic logic [CNT_W-1:0] cal_len(input logic [1:0] k);
        case (k)
            CAL_DAC_FS: cal_len = CNT_W'(CAL_DAC_FS_LEN);
            CAL_OFFSET: cal_len = CNT_W'(CAL_OFFSET_LEN);
            default: cal_len = CNT_W'(CAL_FULL_LEN);
        endcase
    endfunction : cal_len

    // The detect cycle already shows busy, so the counters start two short
    localparam logic [CNT_W-1:0] EDGE_LEAD = CNT_W'(2);

    // Busy rises two edges after start falls, inside the 2.5 period limit
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ACCT_IDLE;
            count <= '0;
            cal_armed <= 1'b0;
            cal_sel <= CAL_FULL;
        end else begin
            case (state)
                ACCT_IDLE: begin
                    if (cal_rise) begin
                        cal_armed <= 1'b1;
                        cal_sel <= cal_kind;
                    end
                    // (RULE_02) Falling start edge
                    if (start_fall) begin
                        if (cal_armed || cal_rise) begin
                            // (RULE_06) Calibration busy rise
                            state <= ACCT_CAL;
                            count <= cal_len(cal_rise ? cal_kind : cal_sel) - EDGE_LEAD;
                        end else begin
                            // (RULE_01) Conversion length
                            state <= ACCT_CONV;
                            count <= CNT_W'(CONV_CYCLES) - EDGE_LEAD;
                        end
                    end
                end
                ACCT_CONV: begin
                    if (count == '0) state <= ACCT_IDLE;
                    else count <= count - CNT_W'(1);
                end
                ACCT_CAL: begin
                    cal_armed <= 1'b0;
                    // (RULE_03) (RULE_04) (RULE_05) Calibration lengths
                    // (RULE_14) Busy held to full count
                    if (count == '0) state <= ACCT_IDLE;
                    else count <= count - CNT_W'(1);
                end
                default: state <= ACCT_IDLE;
            endcase
        end
    end

    // (RULE_06) Busy on the detect cycle
    // Waiting for the state register would cost a third edge, past 2.5 periods
    logic busy_early;
    assign busy_early = (state == ACCT_IDLE) && start_fall;
    assign busy = (state != ACCT_IDLE) || busy_early;

    // Buffer between core and serial port
    logic tx_valid;
    logic tx_ready;
    logic [WORD_W-1:0] tx_word;

    acct_buf2 #(
        .WIDTH(WORD_W)
    ) u_buf (
        .clk(sys_clk),
        .rst_n(rst_n),
        .in_valid(result_valid),
        .in_ready(result_ready),
        .in_data(result_data),
        .out_valid(tx_valid),
        .out_ready(tx_ready),
        .out_data(tx_word)
    );

    // Internal shift clock: toggles on sys_clk in modes 4 and 5 while frame select is low
    logic int_sck;
    logic mode_int;
    assign mode_int = mode_internal(interface_mode);

    // (RULE_08) Device drives shift clock
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) int_sck <= 1'b1;
        else if (mode_int && !frame_sync[1]) int_sck <= ~int_sck;
        else int_sck <= 1'b1;
    end

    assign shift_clk_out = int_sck ^ ~edge_select;
    assign shift_clk_oe = mode_int;

    // (RULE_07) External clock in modes 1-3 is host owned
    // (RULE_13) Edge select inverts the external clock reference; in modes 4 and 5 it inverts the output pin instead
    logic sck_ref;
    logic sck_ref_prev;
    assign sck_ref = mode_int ? int_sck : (sck_sync[1] ^ ~edge_select);

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) sck_ref_prev <= 1'b1;
        else sck_ref_prev <= sck_ref;
    end

    // Sync flops reset to a level that need not match the idle clock,
    // so edges are ignored until the pipeline has filled
    logic [2:0] sck_primed;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) sck_primed <= 3'h0;
        else sck_primed <= {sck_primed[1:0], 1'b1};
    end

    logic sck_rise;
    logic sck_fall;
    assign sck_rise = sck_primed[2] && !sck_ref_prev && sck_ref;
    assign sck_fall = sck_primed[2] && sck_ref_prev && !sck_ref;

    // Serial shifter; the external clock is sampled, so it must be slow
    logic [WORD_W-1:0] tx_shift;
    logic [WORD_W-1:0] rx_shift;
    logic [BIT_W-1:0] bit_cnt;
    logic in_frame;
    logic loaded;

    assign tx_ready = !in_frame && !frame_sync[1] ? 1'b0 : (!loaded && frame_sync[1]);

    // (RULE_12) First fall launches the MSB already on the pin
    // Shifting there too would hand the host bit 14 at its first capture
    logic launch;
    assign launch = in_frame && sck_fall && (bit_cnt != '0);

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_shift <= '0;
            loaded <= 1'b0;
        end else if (tx_valid && tx_ready) begin
            tx_shift <= tx_word;
            loaded <= 1'b1;
        end else if (launch) begin
            // (RULE_12) Launch on falling edge
            tx_shift <= {tx_shift[WORD_W-2:0], 1'b0};
        end else if (!frame_sync[1] && bit_cnt == BIT_W'(TX_BITS)) begin
            loaded <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            in_frame <= 1'b0;
            bit_cnt <= '0;
            rx_shift <= '0;
        end else if (frame_sync[1]) begin
            in_frame <= 1'b0;
            bit_cnt <= '0;
        end else begin
            in_frame <= 1'b1;
            // (RULE_12) Capture on rising edge
            if (sck_rise && bit_cnt != BIT_W'(TX_BITS)) begin
                rx_shift <= {rx_shift[WORD_W-2:0], din_sync[1]};
                bit_cnt <= bit_cnt + BIT_W'(1);
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_valid <= 1'b0;
            rx_data <= '0;
        end else begin
            rx_valid <= in_frame && sck_rise && bit_cnt == BIT_W'(TX_BITS - 1);
            if (in_frame && sck_rise && bit_cnt == BIT_W'(TX_BITS - 1))
                rx_data <= {rx_shift[WORD_W-2:0], din_sync[1]};
        end
    end

    // (RULE_09) Output driver follows frame select
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            data_out <= 1'b0;
            data_out_oe <= 1'b0;
        end else begin
            data_out <= tx_shift[WORD_W-1];
            data_out_oe <= !frame_sync[1];
        end
    end

    // Bidirectional pin: driven in modes 4 and 5 as a second data line
    logic din_drive;
    // (RULE_10) (RULE_11) Turnaround on rising edges
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) din_drive <= 1'b0;
        else if (frame_sync[1] || !mode_int) din_drive <= 1'b0;
        else if (sck_rise) din_drive <= (bit_cnt != BIT_W'(TX_BITS - 1));
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            data_in_out <= 1'b0;
            data_in_oe <= 1'b0;
        end else begin
            data_in_out <= tx_shift[WORD_W-1];
            data_in_oe <= din_drive;
        end
    end
endmodule : acct_top
`default_nettype wire
